// ==== hdl/spi_port_cfg.svh ====
/*
  Addresses, field positions, reset values and bus codes of the serial port.
  Assumes it is included by bare name from the design file.
*/
`ifndef SPI_PORT_CFG_SVH
`define SPI_PORT_CFG_SVH

`define SPI_STATUS_ADDR 32'hffff0a00
`define SPI_RX_ADDR 32'hffff0a04
`define SPI_TX_ADDR 32'hffff0a08
`define SPI_DIV_ADDR 32'hffff0a0c
`define SPI_CTRL_ADDR 32'hffff0a10

`define SPI_CTRL_RESET 16'h0000
`define SPI_CTRL_WMASK 16'h1fef
`define SPI_DIV_RESET 8'h1b
`define SPI_RX_RESET 8'h00
`define SPI_SYNC_RESET 4'h8

`define CTL_EN 0
`define CTL_MASTER 1
`define CTL_CPHA 2
`define CTL_CPOL 3
`define CTL_LSB 5
`define CTL_TXMODE 6
`define CTL_UFPREV 7
`define CTL_OVW 8
`define CTL_CONT 12

`define SPI_BITS 4'h8
`define SPI_LAST_BIT 4'h7

`define AXI_OKAY 2'b00
`define AXI_SLVERR 2'b10

`endif

// ==== hdl/spi_port_pkg.sv ====
/*
  Types shared by the serial port: pin bundles and the master sequencer states.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package spi_port_pkg;
  typedef enum logic [1:0] {M_IDLE, M_RUN, M_STALL} master_state_t;

  typedef struct packed {
    logic ss_n;
    logic miso;
    logic mosi;
    logic sclk;
  } pins_in_t;

  typedef struct packed {
    logic sclk_o;
    logic sclk_oe;
    logic mosi_o;
    logic mosi_oe;
    logic miso_o;
    logic miso_oe;
    logic ss_n_o;
    logic ss_n_oe;
  } pins_out_t;
endpackage : spi_port_pkg
`default_nettype wire

// ==== hdl/spi_port_control_status.sv ====
/*
  Byte-wide serial port, master or slave, with control, status, divider and
  holding registers on an AXI4-Lite slave.
  Assumes pins arrive asynchronously and a single clock aclk with synchronous
  active-low reset aresetn; the pad logic resolves the two-way pins.
*/
// Summary of operation
// - On transmit underflow resend previous byte if control bit 7, else send zeros.
// - Master with control bit 6 set: transmit write starts; interrupt on transmit empty.
// - Master with control bit 6 clear: receive read starts; interrupt on receive full.
// - Control bit 5 shifts least significant bit first, otherwise most significant first.
// - Control bit 3 makes the serial clock rest high, otherwise low.
// - Control bit 2 pulses clock at bit start, otherwise at bit end.
// - Control bit 1 selects master driving clock, otherwise slave.
// - Control bit 0 enables the port's pins, shifting and transmit interrupt, not the receive interrupt.
// - Status bit 5 flags byte arriving over unread data; receive read clears.
// - Status bit 4 is status bit 3 or 5; receive read clears.
// - Status bit 3 shows receive holding valid; receive read clears.
// - Status bit 2 flags transmit underflow; transmit write clears.
// - Status bit 1 is bit 0 clear or bit 2 set; write or disable clears.
// - Status bit 0 high from transmit write until that byte is sent.
// - Receive holding is 8-bit read-only, last byte shifted in, resets zero.
// - Transmit holding is 8-bit write-only and queues the byte for sending.
// - Control bit 8 overwrites full receive holding, otherwise new byte dropped.
// - Slave transfers while active-low select is low, byte after byte.
// - Master clock is base clock over twice one plus divider value.
// - Control bit 12 keeps master transferring back to back while data waits.
`default_nettype none
`include "spi_port_cfg.svh"
module spi_port_control_status (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [31:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire spi_port_pkg::pins_in_t pins_in,
  output var spi_port_pkg::pins_out_t pins_out,
  output logic spi_irq
);
  localparam logic [3:0] sync_rst = `SPI_SYNC_RESET;

  // Pin synchronisers: a filtered level follows once stages two and three agree.
  logic [3:0] pin_vec;
  logic [3:0] s1_ff;
  logic [3:0] s2_ff;
  logic [3:0] s3_ff;
  logic [3:0] flt_ff;
  assign pin_vec = {pins_in.ss_n, pins_in.miso, pins_in.mosi, pins_in.sclk};
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_sync
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          s1_ff[gi] <= sync_rst[gi];
          s2_ff[gi] <= sync_rst[gi];
          s3_ff[gi] <= sync_rst[gi];
          flt_ff[gi] <= sync_rst[gi];
        end else begin
          s1_ff[gi] <= pin_vec[gi];
          s2_ff[gi] <= s1_ff[gi];
          s3_ff[gi] <= s2_ff[gi];
          if (s2_ff[gi] == s3_ff[gi]) begin
            flt_ff[gi] <= s3_ff[gi];
          end
        end
      end
    end
  endgenerate
  wire sclk_f = flt_ff[0];
  wire mosi_f = flt_ff[1];
  wire miso_f = flt_ff[2];
  wire ss_n_f = flt_ff[3];

  // Registers.
  logic [15:0] ctrl_ff;
  logic [7:0] div_ff;
  logic [7:0] tx_hold_ff;
  logic tx_full_ff;
  logic [7:0] rx_hold_ff;
  logic rx_full_ff;
  logic ovf_ff;
  logic uf_ff;
  logic sending_ff;
  logic [7:0] prev_ff;

  wire en = ctrl_ff[`CTL_EN];
  wire master = ctrl_ff[`CTL_MASTER];
  wire cpha = ctrl_ff[`CTL_CPHA];
  wire cpol = ctrl_ff[`CTL_CPOL];
  wire lsb = ctrl_ff[`CTL_LSB];
  wire txmode = ctrl_ff[`CTL_TXMODE];
  wire ufprev = ctrl_ff[`CTL_UFPREV];
  wire ovw = ctrl_ff[`CTL_OVW];
  wire cont = ctrl_ff[`CTL_CONT];

  // AXI4-Lite write path: address and data are held independently.
  logic aw_hold_ff;
  logic w_hold_ff;
  logic [31:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic awready_ff;
  logic wready_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  wire aw_take = awvalid & awready_ff;
  wire w_take = wvalid & wready_ff;
  wire wr_do = aw_hold_ff & w_hold_ff & ~bvalid_ff;
  wire nxt_aw_hold = ~wr_do & (aw_hold_ff | aw_take);
  wire nxt_w_hold = ~wr_do & (w_hold_ff | w_take);
  wire wa_status = awaddr_ff == `SPI_STATUS_ADDR;
  wire wa_rx = awaddr_ff == `SPI_RX_ADDR;
  wire wa_tx = awaddr_ff == `SPI_TX_ADDR;
  wire wa_div = awaddr_ff == `SPI_DIV_ADDR;
  wire wa_ctrl = awaddr_ff == `SPI_CTRL_ADDR;
  wire wa_known = wa_status | wa_rx | wa_tx | wa_div | wa_ctrl;
  wire wr_tx = wr_do & wa_tx & wstrb_ff[0];
  wire [15:0] ctrl_wmask = `SPI_CTRL_WMASK;
  wire [15:0] lane_mask = {{8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};
  wire [15:0] ctrl_bits = lane_mask & ctrl_wmask;
  wire [15:0] nxt_ctrl = (ctrl_ff & ~ctrl_bits) | (wdata_ff[15:0] & ctrl_bits);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_ff <= 1'b0;
      w_hold_ff <= 1'b0;
      awaddr_ff <= 32'h00000000;
      wdata_ff <= 32'h00000000;
      wstrb_ff <= 4'h0;
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= `AXI_OKAY;
    end else begin
      aw_hold_ff <= nxt_aw_hold;
      w_hold_ff <= nxt_w_hold;
      awready_ff <= ~nxt_aw_hold;
      wready_ff <= ~nxt_w_hold;
      if (aw_take) begin
        awaddr_ff <= awaddr;
      end
      if (w_take) begin
        wdata_ff <= wdata;
        wstrb_ff <= wstrb;
      end
      if (wr_do) begin
        bvalid_ff <= 1'b1;
        bresp_ff <= wa_known ? `AXI_OKAY : `AXI_SLVERR;
      end else if (bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_ff <= `SPI_CTRL_RESET;
      div_ff <= `SPI_DIV_RESET;
    end else if (wr_do) begin
      if (wa_ctrl) begin
        ctrl_ff <= nxt_ctrl;
      end else if (wa_div && wstrb_ff[0]) begin
        div_ff <= wdata_ff[7:0];
      end
    end
  end

  // Status word and the port interrupt selection.
  wire tx_busy = tx_full_ff | sending_ff;
  wire tx_irq = en & (~tx_busy | uf_ff);
  wire rx_irq = rx_full_ff | ovf_ff;
  wire [7:0] status = {2'b00, ovf_ff, rx_irq, rx_full_ff, uf_ff, tx_irq, tx_busy};

  // AXI4-Lite read path.
  logic arready_ff;
  logic rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0] rresp_ff;
  wire rd_take = arvalid & arready_ff;
  wire nxt_rvalid = rd_take | (rvalid_ff & ~rready);
  wire ra_status = araddr == `SPI_STATUS_ADDR;
  wire ra_rx = araddr == `SPI_RX_ADDR;
  wire ra_tx = araddr == `SPI_TX_ADDR;
  wire ra_div = araddr == `SPI_DIV_ADDR;
  wire ra_ctrl = araddr == `SPI_CTRL_ADDR;
  wire ra_known = ra_status | ra_rx | ra_tx | ra_div | ra_ctrl;
  wire rd_rx = rd_take & ra_rx;
  logic [31:0] rd_word;
  assign rd_word = ra_status ? {24'h000000, status} :
                   ra_rx ? {24'h000000, rx_hold_ff} :
                   ra_div ? {24'h000000, div_ff} :
                   ra_ctrl ? {16'h0000, ctrl_ff} : 32'h00000000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
      rresp_ff <= `AXI_OKAY;
    end else begin
      arready_ff <= ~nxt_rvalid;
      rvalid_ff <= nxt_rvalid;
      if (rd_take) begin
        rdata_ff <= rd_word;
        rresp_ff <= ra_known ? `AXI_OKAY : `AXI_SLVERR;
      end
    end
  end

  // Master sequencer: half-period ticks from the divider.
  spi_port_pkg::master_state_t state_ff;
  logic [7:0] hcnt_ff;
  logic phase_ff;
  logic rd_req_ff;
  logic [3:0] bitcnt_ff;
  logic reload_ff;
  wire tick = hcnt_ff == div_ff;
  wire m_want = txmode ? tx_full_ff : rd_req_ff;
  wire m_start = en & master & (state_ff == spi_port_pkg::M_IDLE) & m_want;
  wire m_run = state_ff == spi_port_pkg::M_RUN;
  wire lead_m = m_run & tick & ~phase_ff;
  wire trail_m = m_run & tick & phase_ff;
  wire last_trail = trail_m & (cpha ? bitcnt_ff == `SPI_LAST_BIT : reload_ff);
  wire cont_go = cont & tx_full_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= spi_port_pkg::M_IDLE;
      hcnt_ff <= 8'h00;
      phase_ff <= 1'b0;
      rd_req_ff <= 1'b0;
    end else begin
      if (rd_rx && master && !txmode) begin
        rd_req_ff <= 1'b1;
      end else if (m_start || !en || !master) begin
        rd_req_ff <= 1'b0;
      end
      hcnt_ff <= (tick || state_ff == spi_port_pkg::M_IDLE) ? 8'h00 : hcnt_ff + 8'h01;
      if (!en || !master) begin
        state_ff <= spi_port_pkg::M_IDLE;
        phase_ff <= 1'b0;
      end else begin
        case (state_ff)
          spi_port_pkg::M_IDLE: begin
            if (m_start) begin
              state_ff <= spi_port_pkg::M_RUN;
            end
          end
          spi_port_pkg::M_RUN: begin
            if (tick) begin
              phase_ff <= ~phase_ff;
            end
            if (last_trail && !cont_go) begin
              state_ff <= spi_port_pkg::M_STALL;
            end
          end
          spi_port_pkg::M_STALL: begin
            if (tick) begin
              state_ff <= spi_port_pkg::M_IDLE;
            end
          end
          default: begin
            state_ff <= spi_port_pkg::M_IDLE;
          end
        endcase
      end
    end
  end

  // Slave edge detection on the filtered pins.
  logic sclk_d_ff;
  logic ss_d_ff;
  wire s_on = en & ~master;
  wire s_active = s_on & ~ss_n_f;
  wire s_edge = s_active & (sclk_f != sclk_d_ff);
  wire lead_s = s_edge & (sclk_f != cpol);
  wire trail_s = s_edge & (sclk_f == cpol);
  wire s_start = s_on & ss_d_ff & ~ss_n_f;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sclk_d_ff <= 1'b0;
      ss_d_ff <= 1'b1;
    end else begin
      sclk_d_ff <= sclk_f;
      ss_d_ff <= ss_n_f;
    end
  end

  // Shared shift engine; drive and sample edges follow the phase setting.
  wire lead = master ? lead_m : lead_s;
  wire trail = master ? trail_m : trail_s;
  wire start = master ? m_start : s_start;
  wire sample = cpha ? trail : lead;
  wire drive = cpha ? lead : trail;
  wire frame_off = master ? ~m_run : (ss_n_f | ~en);
  wire load_now = (start & ~cpha) | (drive & reload_ff & (~master | ~last_trail | cont_go));
  wire shift_now = drive & ~reload_ff & ~start;
  wire byte_done = sample & ~reload_ff & (bitcnt_ff == `SPI_LAST_BIT);
  wire in_bit = master ? miso_f : mosi_f;
  wire [7:0] fill = ufprev ? prev_ff : 8'h00;
  wire [7:0] next_byte = tx_full_ff ? tx_hold_ff : fill;
  logic [7:0] tx_sr_ff;
  logic [7:0] rx_sr_ff;
  logic out_bit_ff;
  wire [7:0] rx_next = lsb ? {in_bit, rx_sr_ff[7:1]} : {rx_sr_ff[6:0], in_bit};
  wire [7:0] tx_shift = lsb ? {1'b0, tx_sr_ff[7:1]} : {tx_sr_ff[6:0], 1'b0};
  wire load_bit = lsb ? next_byte[0] : next_byte[7];
  wire shift_bit = lsb ? tx_shift[0] : tx_shift[7];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bitcnt_ff <= 4'h0;
      reload_ff <= 1'b0;
      tx_sr_ff <= 8'h00;
      rx_sr_ff <= 8'h00;
      out_bit_ff <= 1'b0;
    end else begin
      if (start) begin
        bitcnt_ff <= 4'h0;
        reload_ff <= cpha;
      end else if (frame_off) begin
        bitcnt_ff <= 4'h0;
        reload_ff <= 1'b0;
      end else begin
        if (sample && !reload_ff) begin
          rx_sr_ff <= rx_next;
          bitcnt_ff <= byte_done ? 4'h0 : bitcnt_ff + 4'h1;
        end
        if (byte_done) begin
          reload_ff <= 1'b1;
        end else if (load_now) begin
          reload_ff <= 1'b0;
        end
      end
      if (load_now) begin
        tx_sr_ff <= next_byte;
        out_bit_ff <= load_bit;
      end else if (shift_now) begin
        tx_sr_ff <= tx_shift;
        out_bit_ff <= shift_bit;
      end
    end
  end

  // Holding registers and their flags; a hardware set wins over a clear.
  wire rx_store = byte_done & (~rx_full_ff | rd_rx | ovw);
  wire ovf_set = byte_done & rx_full_ff & ~rd_rx;
  wire uf_set = load_now & ~tx_full_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_hold_ff <= 8'h00;
      tx_full_ff <= 1'b0;
      rx_hold_ff <= `SPI_RX_RESET;
      rx_full_ff <= 1'b0;
      ovf_ff <= 1'b0;
      uf_ff <= 1'b0;
      sending_ff <= 1'b0;
      prev_ff <= 8'h00;
    end else begin
      if (wr_tx) begin
        tx_hold_ff <= wdata_ff[7:0];
        tx_full_ff <= 1'b1;
      end else if (load_now) begin
        tx_full_ff <= 1'b0;
      end
      if (load_now) begin
        prev_ff <= next_byte;
      end
      if (load_now && tx_full_ff) begin
        sending_ff <= 1'b1;
      end else if (byte_done || frame_off) begin
        sending_ff <= 1'b0;
      end
      if (uf_set) begin
        uf_ff <= 1'b1;
      end else if (wr_tx) begin
        uf_ff <= 1'b0;
      end
      if (rx_store) begin
        rx_hold_ff <= rx_next;
      end
      if (byte_done) begin
        rx_full_ff <= 1'b1;
      end else if (rd_rx) begin
        rx_full_ff <= 1'b0;
      end
      if (ovf_set) begin
        ovf_ff <= 1'b1;
      end else if (rd_rx) begin
        ovf_ff <= 1'b0;
      end
    end
  end

  // Registered pin drive and interrupt.
  spi_port_pkg::pins_out_t nxt_pins;
  always_comb begin
    nxt_pins.sclk_o = cpol ^ (phase_ff & m_run);
    nxt_pins.sclk_oe = en & master;
    nxt_pins.mosi_o = out_bit_ff;
    nxt_pins.mosi_oe = en & master;
    nxt_pins.miso_o = out_bit_ff;
    nxt_pins.miso_oe = s_active;
    nxt_pins.ss_n_o = ~m_run;
    nxt_pins.ss_n_oe = en & master;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pins_out <= '0;
      spi_irq <= 1'b0;
    end else begin
      pins_out <= nxt_pins;
      spi_irq <= txmode ? tx_irq : rx_irq;
    end
  end

  assign awready = awready_ff;
  assign wready = wready_ff;
  assign bvalid = bvalid_ff;
  assign bresp = bresp_ff;
  assign arready = arready_ff;
  assign rvalid = rvalid_ff;
  assign rdata = rdata_ff;
  assign rresp = rresp_ff;
endmodule : spi_port_control_status
`default_nettype wire

// ==== tb/spi_port_control_status_assertions.sv ====
/*
  Concurrent checks on the serial port's bus handshakes and pin drive.
  Assumes it is bound to the port's top module and sees only its ports.
*/
`default_nettype none
module spi_port_control_status_assertions (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] awaddr,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [31:0] araddr,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  input wire logic rready,
  input wire spi_port_pkg::pins_in_t pins_in,
  input wire spi_port_pkg::pins_out_t pins_out,
  input wire logic spi_irq
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // Counts clock edges inside a driven frame; a frame must end on a whole byte.
  logic [4:0] edge_cnt_ff;
  always_ff @(posedge aclk) begin
    if (!aresetn || !pins_out.ss_n_oe || !$past(pins_out.ss_n_oe) || (pins_out.ss_n_o && $past(pins_out.ss_n_o))) begin
      edge_cnt_ff <= 5'h00;
    end else if (pins_out.sclk_o != $past(pins_out.sclk_o)) begin
      edge_cnt_ff <= edge_cnt_ff + 5'h01;
    end
  end
  a_write_answer: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
    else $error("write answer not on time");
  a_b_release: assert property (bvalid && bready |=> !bvalid)
    else $error("write answer stayed after take");
  a_aw_closed: assert property (awvalid && awready |=> !awready ##1 (awready || wready))
    else $error("write address reopened early");
  a_read_answer: assert property (arvalid && arready |=> rvalid && !arready)
    else $error("read answer not on time");
  a_r_release: assert property (rvalid && rready |=> !rvalid)
    else $error("read answer stayed after take");
  a_err_data: assert property (rvalid && rresp == 2'b10 |-> rdata == 32'h0)
    else $error("refused read carried data");
  a_drive_excl: assert property (!(pins_out.miso_oe && pins_out.mosi_oe))
    else $error("both data lines driven");
  a_master_pins: assert property (pins_out.sclk_oe |-> pins_out.mosi_oe && pins_out.ss_n_oe)
    else $error("master pins not driven together");
  a_byte_edges: assert property (pins_out.ss_n_oe && pins_out.ss_n_o && $past(pins_out.ss_n_o)
    && !$past(pins_out.ss_n_o, 2) |-> edge_cnt_ff[3:0] == 4'h0)
    else $error("frame ended off a byte");
endmodule : spi_port_control_status_assertions
`default_nettype wire

// ==== tb/spi_slave_model.sv ====
/*
  Behavioural serial slave, clock idle low, sample on rising edge, MSB first.
  Assumes select, clock and data come from the port's master pins.
*/
`default_nettype none
module spi_slave_model (
  input wire logic sclk,
  input wire logic ss_n,
  input wire logic mosi,
  input wire logic [7:0] reply,
  output logic miso,
  output logic [7:0] got
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] tx_sh;
  logic [7:0] rx_sh;
  int n_bits;
  initial begin
    miso = 1'b0;
    got = 8'h00;
  end
  always @(negedge ss_n) begin
    tx_sh = reply;
    n_bits = 0;
    miso = reply[7];
  end
  always @(posedge sclk) begin
    if (!ss_n) begin
      rx_sh = {rx_sh[6:0], mosi};
      n_bits = n_bits + 1;
      if (n_bits % 8 == 0) got = rx_sh;
    end
  end
  always @(negedge sclk) begin
    if (!ss_n) begin
      tx_sh = {tx_sh[6:0], 1'b0};
      miso = tx_sh[7];
    end
  end
  // A deselected line flips so that a stale bit cannot pass for data.
  always @(posedge ss_n) miso = ~miso;
endmodule : spi_slave_model
`default_nettype wire

// ==== tb/spi_port_control_status_tb.sv ====
/*
  Self-checking bench: register map, master transfers, bit order, overflow, underflow.
  Assumes the package, design, checker and slave model are compiled before it.
*/
`default_nettype none
`include "spi_port_cfg.svh"
module spi_port_control_status_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk;
  logic aresetn;
  logic [31:0] awaddr;
  logic awvalid;
  logic awready;
  logic [31:0] wdata;
  logic [3:0] wstrb;
  logic wvalid;
  logic wready;
  logic [1:0] bresp;
  logic bvalid;
  logic bready;
  logic [31:0] araddr;
  logic arvalid;
  logic arready;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic rready;
  spi_port_pkg::pins_in_t pins_in;
  spi_port_pkg::pins_out_t pins_out;
  logic spi_irq;
  logic model_miso;
  logic [7:0] reply;
  logic [7:0] got;
  logic [31:0] rv;
  logic [1:0] resp;
  int cnt;
  int n_fail;
  int n_checks;
  // Released select is pulled up; released clock and mosi settle low; released miso follows the slave model.
  assign pins_in = {pins_out.ss_n_oe ? pins_out.ss_n_o : 1'b1, pins_out.miso_oe ? pins_out.miso_o : model_miso,
                    pins_out.mosi_oe ? pins_out.mosi_o : 1'b0, pins_out.sclk_oe ? pins_out.sclk_o : 1'b0};
  spi_port_control_status u_dut (.*);
  spi_slave_model u_slave (.sclk(pins_in.sclk), .ss_n(pins_in.ss_n), .mosi(pins_in.mosi), .reply(reply),
                           .miso(model_miso), .got(got));
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int t = 0; t < 100; t++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    if (bvalid !== 1'b1) n_fail++;
    r = bresp;
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int t = 0; t < 100; t++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    if (rvalid !== 1'b1) n_fail++;
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : rd
  task automatic rd_chk(input logic [31:0] a, input logic [31:0] e);
    rd(a, rv, resp);
    chk(rv, e);
  endtask : rd_chk
  task automatic wait_st(input logic [7:0] m);
    for (int t = 0; t < 200; t++) begin
      rd(`SPI_STATUS_ADDR, rv, resp);
      if ((rv[7:0] & m) !== 8'h00) break;
    end
    if ((rv[7:0] & m) === 8'h00) n_fail++;
  endtask : wait_st
  task automatic t_reset();
    rd_chk(`SPI_STATUS_ADDR, 32'h0);
    rd_chk(`SPI_CTRL_ADDR, 32'h0);
    rd_chk(`SPI_DIV_ADDR, 32'h1b);
    wr(`SPI_RX_ADDR, 32'h55, resp);
    rd_chk(`SPI_RX_ADDR, 32'h0);
    rd_chk(`SPI_TX_ADDR, 32'h0);
    rd(32'hffff0a14, rv, resp);
    chk({30'h0, resp}, {30'h0, `AXI_SLVERR});
  endtask : t_reset
  task automatic t_master();
    wr(`SPI_DIV_ADDR, 32'h7, resp);
    wr(`SPI_CTRL_ADDR, 32'h43, resp);
    rd_chk(`SPI_STATUS_ADDR, 32'h02);
    chk({31'h0, spi_irq}, 32'h1);
    reply = 8'h3c;
    wr(`SPI_TX_ADDR, 32'ha5, resp);
    rd_chk(`SPI_STATUS_ADDR, 32'h01);
    chk({31'h0, spi_irq}, 32'h0);
    for (int t = 0; t < 100 && pins_out.sclk_o === 1'b1; t++) @(posedge aclk);
    for (int t = 0; t < 100 && pins_out.sclk_o === 1'b0; t++) @(posedge aclk);
    for (cnt = 0; cnt < 100 && pins_out.sclk_o === 1'b1; cnt++) @(posedge aclk);
    chk(cnt, 32'd8);
    wait_st(8'h08);
    chk({24'h0, got}, 32'ha5);
    rd_chk(`SPI_STATUS_ADDR, 32'h1a);
    rd_chk(`SPI_RX_ADDR, 32'h3c);
    rd_chk(`SPI_STATUS_ADDR, 32'h02);
  endtask : t_master
  task automatic t_lsb_overflow();
    for (int ow = 0; ow < 2; ow++) begin
      wr(`SPI_CTRL_ADDR, ow ? 32'h163 : 32'h63, resp);
      reply = 8'h12;
      wr(`SPI_TX_ADDR, 32'h01, resp);
      wait_st(8'h08);
      chk({24'h0, got}, 32'h80);
      reply = 8'h06;
      wr(`SPI_TX_ADDR, 32'h0f, resp);
      wait_st(8'h20);
      rd_chk(`SPI_STATUS_ADDR, 32'h3a);
      chk({24'h0, got}, 32'hf0);
      rd_chk(`SPI_RX_ADDR, ow ? 32'h60 : 32'h48);
      rd_chk(`SPI_STATUS_ADDR, 32'h02);
    end
  endtask : t_lsb_overflow
  task automatic t_cont();
    wr(`SPI_CTRL_ADDR, 32'h1043, resp);
    reply = 8'h3c;
    wr(`SPI_TX_ADDR, 32'h11, resp);
    wr(`SPI_TX_ADDR, 32'h22, resp);
    wait_st(8'h20);
    chk({24'h0, got}, 32'h22);
    chk(u_slave.n_bits, 32'd16);
    rd_chk(`SPI_STATUS_ADDR, 32'h3a);
    rd_chk(`SPI_RX_ADDR, 32'h3c);
  endtask : t_cont
  task automatic t_underflow();
    wr(`SPI_CTRL_ADDR, 32'h83, resp);
    wr(`SPI_TX_ADDR, 32'h5a, resp);
    rd_chk(`SPI_STATUS_ADDR, 32'h01);
    reply = 8'h00;
    rd(`SPI_RX_ADDR, rv, resp);
    wait_st(8'h08);
    chk({24'h0, got}, 32'h5a);
    chk({31'h0, spi_irq}, 32'h1);
    rd(`SPI_RX_ADDR, rv, resp);
    wait_st(8'h08);
    chk({24'h0, got}, 32'h5a);
    rd_chk(`SPI_STATUS_ADDR, 32'h1e);
    wr(`SPI_CTRL_ADDR, 32'h03, resp);
    rd(`SPI_RX_ADDR, rv, resp);
    wait_st(8'h08);
    chk({24'h0, got}, 32'h00);
    wr(`SPI_TX_ADDR, 32'h77, resp);
    rd_chk(`SPI_STATUS_ADDR, 32'h19);
  endtask : t_underflow
  task automatic t_pins();
    wr(`SPI_CTRL_ADDR, 32'h0b, resp);
    repeat (4) @(posedge aclk);
    chk({28'h0, pins_out.sclk_o, pins_out.sclk_oe, pins_out.ss_n_oe, pins_out.mosi_oe}, 32'hf);
    wr(`SPI_CTRL_ADDR, 32'h01, resp);
    repeat (4) @(posedge aclk);
    chk({29'h0, pins_out.sclk_oe, pins_out.ss_n_oe, pins_out.mosi_oe}, 32'h0);
    wr(`SPI_CTRL_ADDR, 32'h00, resp);
    repeat (4) @(posedge aclk);
    chk({29'h0, pins_out.ss_n_oe, pins_out.mosi_oe, pins_out.miso_oe}, 32'h0);
  endtask : t_pins
  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (40000) @(posedge aclk);
    n_fail++;
    report_and_stop();
  end
  initial begin
    {aresetn, awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready} = '0;
    wstrb = 4'hf;
    reply = 8'h00;
    n_fail = 0;
    n_checks = 0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_reset();
    t_master();
    t_lsb_overflow();
    t_cont();
    t_underflow();
    t_pins();
    report_and_stop();
  end
endmodule : spi_port_control_status_tb
bind spi_port_control_status spi_port_control_status_assertions u_chk (.*);
`default_nettype wire
